//--- rtl/dtp_top.sv
// timer 0 and timer 1 with pwm waveform outputs
`timescale 1ns/1ps
// Overview of operation
// - timer1 wave enable bit 7 drives a pwm waveform on the timer1 pin.
// - timer0 wave enable bit 6 drives pwm on the timer0 pin independently.
// - log prescale field gives field plus one low bits; resets to five bits.
// - overflow flags keep working; timer1 still supplies the baud tick.
// - gate low level halts counting and so the waveform.
// - output rises when high counter passes zero, falls on compare match.
// - duty reload reaches the compare latch only on the ff to 00 wrap.
// - duty of zero keeps the output low.
// - mode 0 low byte is a power of two prescaler before the high count.
// - mode 1 low byte is a linear prescaler reloaded on overflow.
// - mode 2 is an 8 bit auto reload timer toggling the pin on overflow.
// - mode 2 leaves duty and low reload registers free as storage.
// - timer1 in mode 3 holds its count as if its run bit were clear.
// - timer0 mode 3 low byte is a pwm counter under timer0 controls.
// - timer0 mode 3 high byte is a timer using timer1 run, enable, flag.
// - split duties come from timer0 low reload and timer0 high reload.
// - split period is 256 times shared prescaler plus one.
// - with timer0 split, timer1 runs outside its mode 3 and stops in it.
// - each channel has four modes chosen by its timer mode bits.
// - gate set needs the irq pin high and run set; else run alone.
// - mode bits encode modes 0 to 3 as 00, 01, 10, 11.
module dtp_top (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       ext_irq0_pin_i,
    input  wire logic       ext_irq1_pin_i,
    output logic            timer0_pin_o,
    output logic            timer0_pin_oe_o,
    output logic            timer1_pin_o,
    output logic            timer1_pin_oe_o,
    output logic            timer0_overflow_flag_o,
    output logic            timer1_overflow_flag_o,
    output logic            baud_tick_o
);
    // ========================================
    // state
    logic [7:0] timer_pwm_prescale_control_q;
    logic [7:0] timer_mode_register_q;
    logic [7:0] timer0_low_byte_q;
    logic [7:0] timer0_high_byte_q;
    logic [7:0] timer1_low_byte_q;
    logic [7:0] timer1_high_byte_q;
    logic [7:0] timer0_low_reload_q;
    logic [7:0] timer1_low_reload_q;
    logic [7:0] timer0_duty_reload_q;
    logic [7:0] timer1_duty_reload_q;
    logic [3:0] shared_timer_prescaler_q;
    logic [3:0] tps_cnt_q;
    logic       timer0_run_q;
    logic       timer1_run_q;
    logic [1:0] irq0_sync_q;
    logic [1:0] irq1_sync_q;

    dtp_pkg::dtp_mode_t md0;
    dtp_pkg::dtp_mode_t md1;
    logic        split;
    logic        tick;
    logic        go0;
    logic        go1;
    logic        en0;
    logic        en0h;
    logic        en1;
    logic [17:0] nx0;
    logic [17:0] nx1;
    logic        set0;
    logic        set1;
    logic        t1ov;
    logic        w_tl0;
    logic        w_th0;
    logic        w_tl1;
    logic        w_th1;
    logic        w_run;
    logic        c0_step;
    logic        c1_step;
    logic [7:0]  c0_next;
    logic [7:0]  c1_next;
    logic [7:0]  c0_duty;
    logic [7:0]  c1_duty;

    // ========================================
    // helpers
    function automatic logic [7:0] lmask(input logic [2:0] psc);
        lmask = dtp_pkg::BYTE_MAX >> (dtp_pkg::PSC_TOP - psc);
    endfunction

    // returns {high ovf, low ovf, next high, next low}
    function automatic logic [17:0] tnext(
        input dtp_pkg::dtp_mode_t md,
        input logic       pwm,
        input logic [7:0] tl,
        input logic [7:0] th,
        input logic [7:0] rl,
        input logic [7:0] rh,
        input logic [2:0] psc
    );
        logic [7:0] m;
        logic       lov;
        logic       hov;
        logic [7:0] ntl;
        logic [7:0] nth;
        m   = lmask(psc);
        lov = 1'b0;
        hov = 1'b0;
        ntl = tl;
        nth = th;
        case (md)
            dtp_pkg::DTP_M_LOG: begin
                lov = (tl & m) == m;
                hov = lov && th == dtp_pkg::BYTE_MAX;
                ntl = lov ? dtp_pkg::BYTE_ZERO : tl + dtp_pkg::BYTE_ONE;
                nth = lov ? th + dtp_pkg::BYTE_ONE : th;
            end
            dtp_pkg::DTP_M_LIN: begin
                lov = tl == dtp_pkg::BYTE_MAX;
                hov = lov && th == dtp_pkg::BYTE_MAX;
                ntl = (lov && pwm) ? rl : tl + dtp_pkg::BYTE_ONE;
                nth = lov ? th + dtp_pkg::BYTE_ONE : th;
                if (hov && !pwm) begin
                    nth = rh;
                    ntl = rl;
                end
            end
            dtp_pkg::DTP_M_TOG: begin
                lov = tl == dtp_pkg::BYTE_MAX;
                ntl = lov ? th : tl + dtp_pkg::BYTE_ONE;
            end
            default: begin
            end
        endcase
        tnext = {hov, lov, nth, ntl};
    endfunction

    // ========================================
    // decode and enables
    assign md0 = dtp_pkg::dtp_mode_t'(
        timer_mode_register_q[dtp_pkg::M0_LSB +: 2]);
    assign md1 = dtp_pkg::dtp_mode_t'(
        timer_mode_register_q[dtp_pkg::M1_LSB +: 2]);
    assign split = md0 == dtp_pkg::DTP_M_SPLIT;
    assign tick  = tps_cnt_q == shared_timer_prescaler_q;
    assign go0 = timer0_run_q
        && (!timer_mode_register_q[dtp_pkg::GATE0_BIT]
        || irq0_sync_q[1]);
    assign go1 = timer1_run_q
        && (!timer_mode_register_q[dtp_pkg::GATE1_BIT]
        || irq1_sync_q[1]);
    assign en0  = tick && go0;
    assign en0h = split ? (tick && timer1_run_q) : en0;
    assign en1  = tick && md1 != dtp_pkg::DTP_M_SPLIT
        && (split || go1);

    assign nx0 = tnext(md0,
        timer_pwm_prescale_control_q[dtp_pkg::WAVE0_BIT],
        timer0_low_byte_q, timer0_high_byte_q,
        timer0_low_reload_q, timer0_duty_reload_q,
        timer_pwm_prescale_control_q[dtp_pkg::TIMER0_LOG_PRESCALE_LSB +: 3]);
    assign nx1 = tnext(md1,
        timer_pwm_prescale_control_q[dtp_pkg::WAVE1_BIT],
        timer1_low_byte_q, timer1_high_byte_q,
        timer1_low_reload_q, timer1_duty_reload_q,
        timer_pwm_prescale_control_q[dtp_pkg::TIMER1_LOG_PRESCALE_LSB +: 3]);

    assign w_tl0 = wr_i && addr_i == dtp_pkg::ADDR_TL0;
    assign w_th0 = wr_i && addr_i == dtp_pkg::ADDR_TH0;
    assign w_tl1 = wr_i && addr_i == dtp_pkg::ADDR_TL1;
    assign w_th1 = wr_i && addr_i == dtp_pkg::ADDR_TH1;
    assign w_run = wr_i && addr_i == dtp_pkg::ADDR_RUN;

    // overflow events
    assign t1ov = en1 && (md1 == dtp_pkg::DTP_M_TOG ? nx1[16] : nx1[17]);
    assign set0 = split
        ? (en0 && timer0_low_byte_q == dtp_pkg::BYTE_MAX)
        : (en0 && (md0 == dtp_pkg::DTP_M_TOG ? nx0[16] : nx0[17]));
    assign set1 = split
        ? (en0h && timer0_high_byte_q == dtp_pkg::BYTE_MAX)
        : t1ov;

    // ========================================
    // pin synchronisers
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq0_sync_q <= 2'h0;
            irq1_sync_q <= 2'h0;
        end else begin
            irq0_sync_q <= {irq0_sync_q[0], ext_irq0_pin_i};
            irq1_sync_q <= {irq1_sync_q[0], ext_irq1_pin_i};
        end
    end

    // ========================================
    // shared timer prescaler
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tps_cnt_q <= dtp_pkg::TPS_ZERO;
        end else if (tick) begin
            tps_cnt_q <= dtp_pkg::TPS_ZERO;
        end else begin
            tps_cnt_q <= tps_cnt_q + dtp_pkg::TPS_ONE;
        end
    end

    // ========================================
    // software registers
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer_pwm_prescale_control_q <= dtp_pkg::CTRL_RESET;
            timer_mode_register_q    <= dtp_pkg::BYTE_ZERO;
            timer0_low_reload_q      <= dtp_pkg::BYTE_ZERO;
            timer1_low_reload_q      <= dtp_pkg::BYTE_ZERO;
            timer0_duty_reload_q     <= dtp_pkg::BYTE_ZERO;
            timer1_duty_reload_q     <= dtp_pkg::BYTE_ZERO;
            shared_timer_prescaler_q <= dtp_pkg::TPS_ZERO;
        end else if (wr_i) begin
            case (addr_i)
                dtp_pkg::ADDR_CTRL: timer_pwm_prescale_control_q <= wdata_i;
                dtp_pkg::ADDR_MODE: timer_mode_register_q <= wdata_i;
                dtp_pkg::ADDR_RL0:  timer0_low_reload_q <= wdata_i;
                dtp_pkg::ADDR_RL1:  timer1_low_reload_q <= wdata_i;
                dtp_pkg::ADDR_RH0:  timer0_duty_reload_q <= wdata_i;
                dtp_pkg::ADDR_RH1:  timer1_duty_reload_q <= wdata_i;
                dtp_pkg::ADDR_TPS:
                    shared_timer_prescaler_q <= wdata_i[3:0];
                default: begin
                end
            endcase
        end
    end

    // run bits and sticky overflow flags, set wins over clear
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer0_run_q <= 1'b0;
            timer1_run_q <= 1'b0;
            timer0_overflow_flag_o <= 1'b0;
            timer1_overflow_flag_o <= 1'b0;
        end else begin
            if (w_run) begin
                timer0_run_q <= wdata_i[dtp_pkg::TR0_BIT];
                timer1_run_q <= wdata_i[dtp_pkg::TR1_BIT];
            end
            timer0_overflow_flag_o <= set0 || (timer0_overflow_flag_o
                && !(w_run && !wdata_i[dtp_pkg::TF0_BIT]));
            timer1_overflow_flag_o <= set1 || (timer1_overflow_flag_o
                && !(w_run && !wdata_i[dtp_pkg::TF1_BIT]));
        end
    end

    // ========================================
    // timer 0 counters
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer0_low_byte_q <= dtp_pkg::BYTE_ZERO;
        end else if (w_tl0) begin
            timer0_low_byte_q <= wdata_i;
        end else if (en0) begin
            timer0_low_byte_q <= split
                ? timer0_low_byte_q + dtp_pkg::BYTE_ONE
                : nx0[7:0];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer0_high_byte_q <= dtp_pkg::BYTE_ZERO;
        end else if (w_th0) begin
            timer0_high_byte_q <= wdata_i;
        end else if (en0h) begin
            timer0_high_byte_q <= split
                ? timer0_high_byte_q + dtp_pkg::BYTE_ONE
                : nx0[15:8];
        end
    end

    // ========================================
    // timer 1 counters
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer1_low_byte_q  <= dtp_pkg::BYTE_ZERO;
            timer1_high_byte_q <= dtp_pkg::BYTE_ZERO;
        end else begin
            if (w_tl1) begin
                timer1_low_byte_q <= wdata_i;
            end else if (en1) begin
                timer1_low_byte_q <= nx1[7:0];
            end
            if (w_th1) begin
                timer1_high_byte_q <= wdata_i;
            end else if (en1) begin
                timer1_high_byte_q <= nx1[15:8];
            end
        end
    end

    // baud tick from timer 1 overflow
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            baud_tick_o <= 1'b0;
        end else begin
            baud_tick_o <= t1ov;
        end
    end

    // ========================================
    // read port
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= dtp_pkg::BYTE_ZERO;
        end else if (rd_i) begin
            case (addr_i)
                dtp_pkg::ADDR_CTRL: rdata_o <= timer_pwm_prescale_control_q;
                dtp_pkg::ADDR_MODE: rdata_o <= timer_mode_register_q;
                dtp_pkg::ADDR_TL0:  rdata_o <= timer0_low_byte_q;
                dtp_pkg::ADDR_TH0:  rdata_o <= timer0_high_byte_q;
                dtp_pkg::ADDR_TL1:  rdata_o <= timer1_low_byte_q;
                dtp_pkg::ADDR_TH1:  rdata_o <= timer1_high_byte_q;
                dtp_pkg::ADDR_RL0:  rdata_o <= timer0_low_reload_q;
                dtp_pkg::ADDR_RL1:  rdata_o <= timer1_low_reload_q;
                dtp_pkg::ADDR_RH0:  rdata_o <= timer0_duty_reload_q;
                dtp_pkg::ADDR_RH1:  rdata_o <= timer1_duty_reload_q;
                dtp_pkg::ADDR_TPS:
                    rdata_o <= {4'h0, shared_timer_prescaler_q};
                dtp_pkg::ADDR_RUN:
                    rdata_o <= {timer1_overflow_flag_o, timer1_run_q,
                        timer0_overflow_flag_o, timer0_run_q, 4'h0};
                default: rdata_o <= dtp_pkg::BYTE_ZERO;
            endcase
        end else begin
            rdata_o <= dtp_pkg::BYTE_ZERO;
        end
    end

    // ========================================
    // pwm channels
    assign c0_step = split ? en0 : (en0 && nx0[16]);
    assign c0_next = split
        ? timer0_low_byte_q + dtp_pkg::BYTE_ONE : nx0[15:8];
    assign c0_duty = split ? timer0_low_reload_q
        : timer0_duty_reload_q;
    assign c1_step = split ? en0h : (en1 && nx1[16]);
    assign c1_next = split
        ? timer0_high_byte_q + dtp_pkg::BYTE_ONE : nx1[15:8];
    assign c1_duty = split ? timer0_duty_reload_q
        : timer1_duty_reload_q;

    dtp_chan u_chan0 (
        .clock_i    (clock_i),
        .resetn_i   (resetn_i),
        .en_i       (timer_pwm_prescale_control_q[dtp_pkg::WAVE0_BIT]),
        .step_i     (c0_step),
        .next_i     (c0_next),
        .duty_i     (c0_duty),
        .tog_mode_i (!split && md0 == dtp_pkg::DTP_M_TOG),
        .tog_i      (en0 && nx0[16]),
        .wave_o     (timer0_pin_o)
    );

    dtp_chan u_chan1 (
        .clock_i    (clock_i),
        .resetn_i   (resetn_i),
        .en_i       (timer_pwm_prescale_control_q[dtp_pkg::WAVE1_BIT]),
        .step_i     (c1_step),
        .next_i     (c1_next),
        .duty_i     (c1_duty),
        .tog_mode_i (!split && md1 == dtp_pkg::DTP_M_TOG),
        .tog_i      (en1 && nx1[16]),
        .wave_o     (timer1_pin_o)
    );

    // output enables follow the wave enable bits
    assign timer0_pin_oe_o =
        timer_pwm_prescale_control_q[dtp_pkg::WAVE0_BIT];
    assign timer1_pin_oe_o =
        timer_pwm_prescale_control_q[dtp_pkg::WAVE1_BIT];

    // ========================================
    // assertions
    a_t1_mode3_hold: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        md1 == dtp_pkg::DTP_M_SPLIT && !w_tl1 && !w_th1
        |=> $stable(timer1_low_byte_q) && $stable(timer1_high_byte_q))
        else $error("timer 1 counted in mode 3");
    a_gate_halts_low: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        timer_mode_register_q[dtp_pkg::GATE0_BIT] && !irq0_sync_q[1]
        && !w_tl0 |=> $stable(timer0_low_byte_q))
        else $error("timer 0 counted with gate closed");
    a_flag_sticky: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        set0 |=> timer0_overflow_flag_o ##1
        (timer0_overflow_flag_o || $past(w_run)))
        else $error("timer 0 overflow flag not set or held");
    a_baud_from_t1: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        t1ov |=> baud_tick_o ##1 (baud_tick_o == $past(t1ov)))
        else $error("baud tick does not follow timer 1 overflow");
    a_split_period: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        split && en0 && !w_tl0
        |=> timer0_low_byte_q == $past(timer0_low_byte_q)
        + dtp_pkg::BYTE_ONE)
        else $error("split low counter did not step by one");

    c_split_wave: cover property (
        @(posedge clock_i) disable iff (!resetn_i)
        split && $rose(timer0_pin_o));
    c_tog_wave: cover property (
        @(posedge clock_i) disable iff (!resetn_i)
        md1 == dtp_pkg::DTP_M_TOG && $fell(timer1_pin_o));
    c_log_wave: cover property (
        @(posedge clock_i) disable iff (!resetn_i)
        md0 == dtp_pkg::DTP_M_LOG && $fell(timer0_pin_o));
endmodule

//--- shared/dtp_pkg.sv
// constants and types shared by the dual timer pwm block
package dtp_pkg;
    // ========================================
    // register addresses
    localparam logic [7:0] ADDR_RUN  = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_TL0  = 8'h8a;
    localparam logic [7:0] ADDR_TL1  = 8'h8b;
    localparam logic [7:0] ADDR_TH0  = 8'h8c;
    localparam logic [7:0] ADDR_TH1  = 8'h8d;
    localparam logic [7:0] ADDR_CTRL = 8'h91;
    localparam logic [7:0] ADDR_RL0  = 8'h92;
    localparam logic [7:0] ADDR_RL1  = 8'h93;
    localparam logic [7:0] ADDR_RH0  = 8'h94;
    localparam logic [7:0] ADDR_RH1  = 8'h95;
    localparam logic [7:0] ADDR_TPS  = 8'h96;

    // ========================================
    // reset values and field positions
    localparam logic [7:0] CTRL_RESET = 8'h24;
    localparam int WAVE1_BIT = 7;
    localparam int WAVE0_BIT = 6;
    localparam int TIMER1_LOG_PRESCALE_LSB  = 3;
    localparam int TIMER0_LOG_PRESCALE_LSB  = 0;
    localparam int GATE1_BIT = 7;
    localparam int M1_LSB    = 4;
    localparam int GATE0_BIT = 3;
    localparam int M0_LSB    = 0;
    localparam int TR0_BIT   = 4;
    localparam int TF0_BIT   = 5;
    localparam int TR1_BIT   = 6;
    localparam int TF1_BIT   = 7;

    // ========================================
    // arithmetic constants
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE  = 8'h01;
    localparam logic [7:0] BYTE_MAX  = 8'hff;
    localparam logic [2:0] PSC_TOP   = 3'h7;
    localparam logic [3:0] TPS_ZERO  = 4'h0;
    localparam logic [3:0] TPS_ONE   = 4'h1;

    // ========================================
    // timer operating modes
    typedef enum logic [1:0] {
        DTP_M_LOG   = 2'h0,
        DTP_M_LIN   = 2'h1,
        DTP_M_TOG   = 2'h2,
        DTP_M_SPLIT = 2'h3
    } dtp_mode_t;
endpackage

//--- rtl/dtp_chan.sv
// one pwm compare channel with latched compare and toggle option
`timescale 1ns/1ps
module dtp_chan (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic       en_i,
    input  wire logic       step_i,
    input  wire logic [7:0] next_i,
    input  wire logic [7:0] duty_i,
    input  wire logic       tog_mode_i,
    input  wire logic       tog_i,
    output logic            wave_o
);
    logic [7:0] active_compare_value_q;
    logic       wrap;

    assign wrap = step_i && (next_i == dtp_pkg::BYTE_ZERO);

    // ========================================
    // compare latch
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            active_compare_value_q <= dtp_pkg::BYTE_ZERO;
        end else if (wrap) begin
            active_compare_value_q <= duty_i;
        end
    end

    // ========================================
    // waveform
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wave_o <= 1'b0;
        end else if (!en_i) begin
            wave_o <= 1'b0;
        end else if (tog_mode_i) begin
            if (tog_i) begin
                wave_o <= !wave_o;
            end
        end else if (wrap) begin
            wave_o <= (duty_i != dtp_pkg::BYTE_ZERO);
        end else if (step_i && next_i == active_compare_value_q) begin
            wave_o <= 1'b0;
        end
    end

    // ========================================
    // assertions
    a_zero_duty_low: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        wrap && !tog_mode_i && duty_i == dtp_pkg::BYTE_ZERO
        |=> !wave_o [*1] ##1 (!wave_o || $past(step_i) || $past(tog_i)))
        else $error("zero duty did not hold output low");
    a_wrap_sets_high: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        en_i && wrap && !tog_mode_i && duty_i != dtp_pkg::BYTE_ZERO
        |=> wave_o)
        else $error("output not set high on counter wrap");
    a_match_clears: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        step_i && !wrap && !tog_mode_i
        && next_i == active_compare_value_q |=> !wave_o)
        else $error("output not cleared on compare match");
    a_compare_load_wrap: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        !wrap |=> $stable(active_compare_value_q))
        else $error("compare value changed away from wrap");
    a_toggle_flips: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        en_i && tog_mode_i && tog_i |=> wave_o != $past(wave_o))
        else $error("output did not toggle on low byte overflow");
    a_disabled_low: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        !en_i |=> !wave_o)
        else $error("waveform driven while disabled");
endmodule

//--- bench/dtp_load.sv
// pin load: pulled up wherever the timer releases its pin
`timescale 1ns/1ps
module dtp_load (
    input  wire logic pin0_i,
    input  wire logic oe0_i,
    input  wire logic pin1_i,
    input  wire logic oe1_i,
    output logic      lvl0_o,
    output logic      lvl1_o
);
    assign lvl0_o = oe0_i ? pin0_i : 1'b1;
    assign lvl1_o = oe1_i ? pin1_i : 1'b1;
endmodule

//--- bench/testbench.sv
// register-level tests of the dual timer pwm block
`timescale 1ns/1ps
module testbench;
    logic       clock_i  = 1'b0;
    logic       resetn_i = 1'b0;
    logic [7:0] addr_i   = 8'h00;
    logic [7:0] wdata_i  = 8'h00;
    logic       wr_i     = 1'b0;
    logic       rd_i     = 1'b0;
    logic       irq0     = 1'b1;
    logic [7:0] rdata_o;
    logic       p0, e0, p1, e1, l0, l1, bt;
    logic [15:0] bc;
    int         miscompares = 0;
    int         n_checks    = 0;
    always #2 clock_i = ~clock_i;
    dtp_top i_dtp_top (.clock_i(clock_i), .resetn_i(resetn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .ext_irq0_pin_i(irq0), .ext_irq1_pin_i(1'b1),
        .timer0_pin_o(p0), .timer0_pin_oe_o(e0), .timer1_pin_o(p1),
        .timer1_pin_oe_o(e1), .timer0_overflow_flag_o(),
        .timer1_overflow_flag_o(), .baud_tick_o(bt));
    dtp_load i_dtp_load (.pin0_i(p0), .oe0_i(e0), .pin1_i(p1),
        .oe1_i(e1), .lvl0_o(l0), .lvl1_o(l1));
    // ========================================
    // access and measurement tasks
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1 chk("read data", {8'h00, e}, {8'h00, rdata_o});
    endtask
    // count high cycles and rising edges seen at the load
    task automatic wv(input int n, input logic ch, input logic [15:0] eh,
                      input logic [15:0] er);
        logic [15:0] hi = 16'h0000;
        logic [15:0] rs = 16'h0000;
        logic        pv, c;
        @(negedge clock_i);
        pv = ch ? l1 : l0;
        repeat (n) begin
            @(negedge clock_i);
            c  = ch ? l1 : l0;
            hi = hi + {15'h0000, c};
            rs = rs + {15'h0000, c & ~pv};
            pv = c;
        end
        if (eh !== 16'hffff) chk("high cycles", eh, hi);
        chk("rising edges", er, rs);
    endtask
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ========================================
    // test sequence
    initial begin
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        rc(dtp_pkg::ADDR_CTRL, 8'h24);
        chk("pin enables", 16'h0000, {14'h0000, e1, e0});
        rc(8'h80, 8'h00);
        wr(dtp_pkg::ADDR_RL0, 8'hff);
        wr(dtp_pkg::ADDR_RH0, 8'h40);
        wr(dtp_pkg::ADDR_MODE, 8'h01);
        wr(dtp_pkg::ADDR_CTRL, 8'h64);
        wr(dtp_pkg::ADDR_RUN, 8'h10);
        repeat (600) @(posedge clock_i);
        wv(1024, 1'b0, 16'h0100, 16'h0004);
        wv(256, 1'b1, 16'h0100, 16'h0000);
        rc(dtp_pkg::ADDR_RUN, 8'h30);
        wr(dtp_pkg::ADDR_RH0, 8'h00);
        repeat (300) @(posedge clock_i);
        wv(512, 1'b0, 16'h0000, 16'h0000);
        wr(dtp_pkg::ADDR_RH0, 8'h80);
        wr(dtp_pkg::ADDR_CTRL, 8'h40);
        wr(dtp_pkg::ADDR_MODE, 8'h00);
        repeat (1100) @(posedge clock_i);
        wv(1024, 1'b0, 16'h0200, 16'h0002);
        wr(dtp_pkg::ADDR_MODE, 8'h02);
        wr(dtp_pkg::ADDR_TH0, 8'hfe);
        wr(dtp_pkg::ADDR_RL0, 8'h12);
        repeat (600) @(posedge clock_i);
        wv(400, 1'b0, 16'h00c8, 16'h0064);
        rc(dtp_pkg::ADDR_RL0, 8'h12);
        wr(dtp_pkg::ADDR_MODE, 8'h0a);
        irq0 <= 1'b0;
        repeat (8) @(posedge clock_i);
        wv(400, 1'b0, 16'hffff, 16'h0000);
        irq0 <= 1'b1;
        repeat (8) @(posedge clock_i);
        wv(400, 1'b0, 16'h00c8, 16'h0064);
        wr(dtp_pkg::ADDR_TPS, 8'h01);
        wr(dtp_pkg::ADDR_RL0, 8'h20);
        wr(dtp_pkg::ADDR_RH0, 8'h60);
        wr(dtp_pkg::ADDR_MODE, 8'h03);
        wr(dtp_pkg::ADDR_CTRL, 8'he4);
        wr(dtp_pkg::ADDR_RUN, 8'h50);
        repeat (1100) @(posedge clock_i);
        wv(1024, 1'b0, 16'h0080, 16'h0002);
        wv(1024, 1'b1, 16'h0180, 16'h0002);
        rc(dtp_pkg::ADDR_RUN, 8'hf0);
        wr(dtp_pkg::ADDR_MODE, 8'h23);
        wr(dtp_pkg::ADDR_TH1, 8'h80);
        repeat (600) @(posedge clock_i);
        bc = 16'h0000;
        repeat (1024) begin
            @(negedge clock_i);
            bc = bc + {15'h0000, bt};
        end
        chk("baud ticks", 16'h0004, bc);
        wr(dtp_pkg::ADDR_MODE, 8'h33);
        wr(dtp_pkg::ADDR_TH1, 8'h5a);
        repeat (300) @(posedge clock_i);
        rc(dtp_pkg::ADDR_TH1, 8'h5a);
        wr(dtp_pkg::ADDR_CTRL, 8'h24);
        repeat (2) @(posedge clock_i);
        wv(16, 1'b0, 16'h0010, 16'h0000);
        end_of_test();
    end
endmodule
